// File: hdl/system_clock_select_power_modes.sv
// System clock source select, prescaler, timed unlock window and the
// IDLE / STOP / SLEEP power modes. Assumes clk is the fast oscillator;
// slow and external clocks and wake pins arrive asynchronously; irq_req
// is the already enabled interrupt request from the same clock domain.
`timescale 1ns/1ps
module system_clock_select_power_modes (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  output logic [7:0] sfr_rdata,
  input wire logic slow_32k_oscillator,
  input wire logic external_clock_input,
  input wire logic [7:0] wake_src,
  input wire logic irq_req,
  output logic system_clock,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic fast_osc_en,
  output logic main_reg_en,
  output logic cpu_resume,
  output logic unlock_open
);

  clk_pm_pkg::pm_state_e state_q;
  clk_pm_pkg::pm_state_e state_d;

  logic [1:0] osc_s1_q;
  logic [1:0] osc_s2_q;
  logic [1:0] osc_s3_q;
  logic [3:0] prescale_q;
  logic [1:0] settle_sel_q;
  logic [1:0] source_q;
  logic [1:0] active_src_q;
  logic [7:0] wake_source_mask_q;
  logic [2:0] req_q;
  logic [2:0] req_d;
  logic key1_q;
  logic [8:0] win_cnt_q;
  logic [8:0] win_cnt_d;
  logic [8:0] settle_cnt_q;
  logic [8:0] settle_cnt_d;
  logic unlock_open_q;
  logic sys_tick_q;
  logic cpu_clk_en_q;
  logic periph_clk_en_q;
  logic fast_osc_en_q;
  logic main_reg_en_q;
  logic cpu_resume_q;
  logic [7:0] sfr_rdata_q;

  wire slow_edge = osc_s2_q[0] & ~osc_s3_q[0];
  wire ext_edge = osc_s2_q[1] & ~osc_s3_q[1];
  wire fast_tick;
  wire wake_any;

  // Register decode
  wire wr_system_clock_select = sfr_we && (sfr_addr == clk_pm_pkg::ADDR_SYSTEM_CLOCK_SELECT);
  wire wr_wake_source_mask = sfr_we && (sfr_addr == clk_pm_pkg::ADDR_WAKE_SOURCE_MASK);
  wire wr_power_control = sfr_we && (sfr_addr == clk_pm_pkg::ADDR_POWER_CONTROL);
  wire wr_unlock = sfr_we && (sfr_addr == clk_pm_pkg::ADDR_UNLOCK);
  wire system_clock_select_ok = wr_system_clock_select && unlock_open_q;
  wire wake_source_mask_ok = wr_wake_source_mask && unlock_open_q;
  wire key1_hit = (sfr_wdata == clk_pm_pkg::UNLOCK_KEY1);
  wire key2_hit = (sfr_wdata == clk_pm_pkg::UNLOCK_KEY2) && key1_q;
  wire close_hit = (sfr_wdata == clk_pm_pkg::UNLOCK_CLOSE);

  // Source selection; 00 and 10 both mean divided fast oscillator
  wire src_tick = (active_src_q == clk_pm_pkg::SRC_SLOW) ? slow_edge :
                  (active_src_q == clk_pm_pkg::SRC_EXT) ? ext_edge :
                  fast_tick;
  wire tree_on = (state_q == clk_pm_pkg::PM_RUN) ||
                 (state_q == clk_pm_pkg::PM_IDLE);
  wire sys_tick = src_tick && tree_on;

  // Power mode events
  wire enter_stop = (state_q == clk_pm_pkg::PM_RUN) &&
                    req_q[clk_pm_pkg::POWER_CONTROL_STOP] && src_tick;
  wire enter_sleep = enter_stop && req_q[clk_pm_pkg::POWER_CONTROL_SLEEP];
  wire enter_idle = (state_q == clk_pm_pkg::PM_RUN) &&
                    !req_q[clk_pm_pkg::POWER_CONTROL_STOP] &&
                    req_q[clk_pm_pkg::POWER_CONTROL_IDLE];
  wire idle_exit = (state_q == clk_pm_pkg::PM_IDLE) && irq_req;
  wire stop_exit = (state_q == clk_pm_pkg::PM_STOP) && wake_any;
  wire sleep_wake = (state_q == clk_pm_pkg::PM_SLEEP) && wake_any;
  wire settle_done = (state_q == clk_pm_pkg::PM_SETTLE) && slow_edge &&
                     (settle_cnt_q == clk_pm_pkg::CNT_ONE);
  wire [2:0] hw_clr = {settle_done,
                       stop_exit || settle_done,
                       idle_exit};
  wire [2:0] sw_set = wr_power_control ?
    sfr_wdata[clk_pm_pkg::POWER_CONTROL_SLEEP:clk_pm_pkg::POWER_CONTROL_IDLE] : 3'h0;

  wire [7:0] rd_system_clock_select = {prescale_q, 2'h0, source_q};
  wire [7:0] rd_unlock = {7'h00, unlock_open_q};
  wire [7:0] rd_val =
    (sfr_addr == clk_pm_pkg::ADDR_SYSTEM_CLOCK_SELECT) ? rd_system_clock_select :
    (sfr_addr == clk_pm_pkg::ADDR_WAKE_SOURCE_MASK) ? wake_source_mask_q :
    (sfr_addr == clk_pm_pkg::ADDR_UNLOCK) ? rd_unlock : 8'h00;

  wake_if #(.N(clk_pm_pkg::WAKE_SRCS)) wk ();
  assign wk.src_raw = wake_src;
  assign wk.mask = wake_source_mask_q;
  assign wake_any = wk.wake;

  wake_edge_detect #(.N(clk_pm_pkg::WAKE_SRCS)) u_wake (
    .clk(clk),
    .rst(rst),
    .port(wk.det)
  );

  fast_osc_prescale u_prescale (
    .clk(clk),
    .rst(rst),
    .en(fast_osc_en_q),
    .code(prescale_q),
    .tick(fast_tick)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      clk_pm_pkg::PM_RUN:
      begin
        if (enter_sleep)
          state_d = clk_pm_pkg::PM_SLEEP;
        else if (enter_stop)
          state_d = clk_pm_pkg::PM_STOP;
        else if (enter_idle)
          state_d = clk_pm_pkg::PM_IDLE;
      end
      clk_pm_pkg::PM_IDLE:
        if (idle_exit)
          state_d = clk_pm_pkg::PM_RUN;
      clk_pm_pkg::PM_STOP:
        if (stop_exit)
          state_d = clk_pm_pkg::PM_RUN;
      clk_pm_pkg::PM_SLEEP:
        if (sleep_wake)
          state_d = clk_pm_pkg::PM_SETTLE;
      clk_pm_pkg::PM_SETTLE:
        if (settle_done)
          state_d = clk_pm_pkg::PM_RUN;
      default:
        state_d = clk_pm_pkg::PM_RUN;
    endcase
  end

  // Set wins over a hardware clear in the same cycle
  assign req_d = (req_q & ~hw_clr) | sw_set;

  assign settle_cnt_d =
    sleep_wake ? clk_pm_pkg::settle_cycles(settle_sel_q) :
    ((state_q == clk_pm_pkg::PM_SETTLE) && slow_edge) ?
      settle_cnt_q - clk_pm_pkg::CNT_ONE : settle_cnt_q;

  assign win_cnt_d =
    (wr_unlock && key2_hit) ? clk_pm_pkg::UNLOCK_TICKS :
    (wr_unlock && close_hit) ? clk_pm_pkg::CNT_ZERO :
    (sys_tick && win_cnt_q != clk_pm_pkg::CNT_ZERO) ?
      win_cnt_q - clk_pm_pkg::CNT_ONE : win_cnt_q;

  always_ff @(posedge clk)
  begin
    osc_s1_q <= {external_clock_input, slow_32k_oscillator};
    osc_s2_q <= osc_s1_q;
    osc_s3_q <= osc_s2_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prescale_q <=
        clk_pm_pkg::SYSTEM_CLOCK_SELECT_RST[clk_pm_pkg::DIV_MSB:clk_pm_pkg::DIV_LSB];
      settle_sel_q <=
        clk_pm_pkg::SYSTEM_CLOCK_SELECT_RST[clk_pm_pkg::DLY_MSB:clk_pm_pkg::DLY_LSB];
      source_q <=
        clk_pm_pkg::SYSTEM_CLOCK_SELECT_RST[clk_pm_pkg::SRC_MSB:clk_pm_pkg::SRC_LSB];
      wake_source_mask_q <= clk_pm_pkg::WAKE_SOURCE_MASK_RST;
    end
    else
    begin
      if (system_clock_select_ok)
      begin
        prescale_q <= sfr_wdata[clk_pm_pkg::DIV_MSB:clk_pm_pkg::DIV_LSB];
        settle_sel_q <=
          sfr_wdata[clk_pm_pkg::DLY_MSB:clk_pm_pkg::DLY_LSB];
        source_q <= sfr_wdata[clk_pm_pkg::SRC_MSB:clk_pm_pkg::SRC_LSB];
      end
      if (wake_source_mask_ok)
        wake_source_mask_q <= sfr_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      key1_q <= 1'b0;
      win_cnt_q <= clk_pm_pkg::CNT_ZERO;
      unlock_open_q <= 1'b0;
      req_q <= 3'h0;
    end
    else
    begin
      key1_q <= wr_unlock ? key1_hit : key1_q;
      win_cnt_q <= win_cnt_d;
      unlock_open_q <= (win_cnt_d != clk_pm_pkg::CNT_ZERO);
      req_q <= req_d;
    end
  end

  // Reset goes through the regulator delay like a sleep wake
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= clk_pm_pkg::PM_SETTLE;
      settle_cnt_q <= clk_pm_pkg::settle_cycles(
        clk_pm_pkg::SYSTEM_CLOCK_SELECT_RST[clk_pm_pkg::DLY_MSB:clk_pm_pkg::DLY_LSB]);
      active_src_q <=
        clk_pm_pkg::SYSTEM_CLOCK_SELECT_RST[clk_pm_pkg::SRC_MSB:clk_pm_pkg::SRC_LSB];
    end
    else
    begin
      state_q <= state_d;
      settle_cnt_q <= settle_cnt_d;
      if (src_tick || !tree_on)
        active_src_q <= source_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sys_tick_q <= 1'b0;
      cpu_clk_en_q <= 1'b0;
      periph_clk_en_q <= 1'b0;
      fast_osc_en_q <= 1'b0;
      main_reg_en_q <= 1'b1;
      cpu_resume_q <= 1'b0;
      sfr_rdata_q <= 8'h00;
    end
    else
    begin
      sys_tick_q <= sys_tick;
      cpu_clk_en_q <= (state_d == clk_pm_pkg::PM_RUN);
      periph_clk_en_q <= (state_d == clk_pm_pkg::PM_RUN) ||
                         (state_d == clk_pm_pkg::PM_IDLE);
      fast_osc_en_q <= (state_d == clk_pm_pkg::PM_RUN) ||
                       (state_d == clk_pm_pkg::PM_IDLE);
      main_reg_en_q <= (state_d != clk_pm_pkg::PM_SLEEP);
      cpu_resume_q <= idle_exit || stop_exit ||
                      (settle_done && req_q[clk_pm_pkg::POWER_CONTROL_STOP]);
      if (sfr_re)
        sfr_rdata_q <= rd_val;
    end
  end

  assign sfr_rdata = sfr_rdata_q;
  assign system_clock = sys_tick_q;
  assign cpu_clk_en = cpu_clk_en_q;
  assign periph_clk_en = periph_clk_en_q;
  assign fast_osc_en = fast_osc_en_q;
  assign main_reg_en = main_reg_en_q;
  assign cpu_resume = cpu_resume_q;
  assign unlock_open = unlock_open_q;

  sequence s_key1;
    wr_unlock && sfr_wdata == clk_pm_pkg::UNLOCK_KEY1;
  endsequence
  sequence s_key2;
    wr_unlock && sfr_wdata == clk_pm_pkg::UNLOCK_KEY2;
  endsequence

  property p_unlock_opens;
    @(posedge clk) disable iff (rst)
      s_key1 ##1 !wr_unlock ##1 s_key2 |=> unlock_open_q;
  endproperty
  a_unlock_opens: assert property (p_unlock_opens)
    else $error("unlock sequence did not open the window");
  property p_unlock_close;
    @(posedge clk) disable iff (rst)
      wr_unlock && close_hit |=> !unlock_open_q;
  endproperty
  a_unlock_close: assert property (p_unlock_close)
    else $error("close write left window open");
  property p_system_clock_select_locked;
    @(posedge clk) disable iff (rst)
      wr_system_clock_select && !unlock_open_q |=>
        $stable(rd_system_clock_select) && $stable(settle_sel_q);
  endproperty
  a_system_clock_select_locked: assert property (p_system_clock_select_locked)
    else $error("clock select changed while locked");
  property p_wake_source_mask_locked;
    @(posedge clk) disable iff (rst)
      wr_wake_source_mask && !unlock_open_q |=> $stable(wake_source_mask_q);
  endproperty
  a_wake_source_mask_locked: assert property (p_wake_source_mask_locked)
    else $error("wake mask changed while locked");
  property p_reset_values;
    @(posedge clk) rst |=> rd_system_clock_select == 8'h00 && settle_sel_q == 2'h3 &&
      wake_source_mask_q == clk_pm_pkg::WAKE_SOURCE_MASK_RST;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("wrong clock select or mask after reset");

  property p_idle_exit;
    @(posedge clk) disable iff (rst)
      idle_exit |=> cpu_clk_en_q && cpu_resume_q &&
                    !req_q[clk_pm_pkg::POWER_CONTROL_IDLE];
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("idle exit did not restart CPU clock");
  property p_idle_gating;
    @(posedge clk) disable iff (rst)
      state_q == clk_pm_pkg::PM_IDLE |-> !cpu_clk_en_q && periph_clk_en_q;
  endproperty
  a_idle_gating: assert property (p_idle_gating)
    else $error("idle clock gating wrong");

  property p_stop_exit;
    @(posedge clk) disable iff (rst)
      stop_exit |=> fast_osc_en_q && !req_q[clk_pm_pkg::POWER_CONTROL_STOP];
  endproperty
  a_stop_exit: assert property (p_stop_exit)
    else $error("stop exit did not restart oscillator");

  property p_osc_last_edge;
    @(posedge clk) disable iff (rst)
      $fell(fast_osc_en_q) && !$past(rst) |-> $past(src_tick);
  endproperty
  a_osc_last_edge: assert property (p_osc_last_edge)
    else $error("oscillator stopped off a tick edge");

  sequence s_sleep_wake;
    sleep_wake;
  endsequence
  property p_sleep_settle;
    @(posedge clk) disable iff (rst)
      s_sleep_wake |=> (main_reg_en_q && !cpu_clk_en_q) [*8];
  endproperty
  a_sleep_settle: assert property (p_sleep_settle)
    else $error("clock released before regulator settled");

endmodule : system_clock_select_power_modes

// File: hdl/clk_pm_pkg.sv
// Constants, field layout and state encoding for the clock select and
// power mode controller. Assumes an 8-bit special function register bus.
package clk_pm_pkg;

  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_SYSTEM_CLOCK_SELECT = 8'h8F;
  localparam logic [7:0] ADDR_WAKE_SOURCE_MASK = 8'h9F;
  localparam logic [7:0] ADDR_UNLOCK = 8'hC9;

  localparam logic [7:0] SYSTEM_CLOCK_SELECT_RST = 8'h0C;
  localparam logic [7:0] WAKE_SOURCE_MASK_RST = 8'hFF;

  localparam int DIV_MSB = 7;
  localparam int DIV_LSB = 4;
  localparam int DLY_MSB = 3;
  localparam int DLY_LSB = 2;
  localparam int SRC_MSB = 1;
  localparam int SRC_LSB = 0;

  localparam int POWER_CONTROL_IDLE = 0;
  localparam int POWER_CONTROL_STOP = 1;
  localparam int POWER_CONTROL_SLEEP = 2;

  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h3;

  localparam logic [7:0] UNLOCK_KEY1 = 8'hAA;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h55;
  localparam logic [7:0] UNLOCK_CLOSE = 8'h00;
  localparam logic [8:0] UNLOCK_TICKS = 9'h100;
  localparam logic [8:0] CNT_ONE = 9'h001;
  localparam logic [8:0] CNT_ZERO = 9'h000;

  localparam int WAKE_SRCS = 8;

  typedef enum logic [2:0] {
    PM_RUN = 3'h0,
    PM_IDLE = 3'h1,
    PM_STOP = 3'h3,
    PM_SLEEP = 3'h2,
    PM_SETTLE = 3'h6
  } pm_state_e;

  // Fast oscillator cycles per system clock tick
  function automatic logic [8:0] prescale_ratio(input logic [3:0] code);
    logic [8:0] r;
    r = 9'h100;
    case (code)
      4'h0: r = 9'h001;
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8:
        r = {4'h0, code, 1'b0};
      4'h9: r = 9'h020;
      4'hA: r = 9'h040;
      4'hB: r = 9'h080;
      default: r = 9'h100;
    endcase
    return r;
  endfunction : prescale_ratio

  // Regulator settling delay in slow oscillator cycles
  function automatic logic [8:0] settle_cycles(input logic [1:0] code);
    logic [8:0] r;
    r = 9'h100;
    case (code)
      2'h0: r = 9'h008;
      2'h1: r = 9'h010;
      2'h2: r = 9'h040;
      default: r = 9'h100;
    endcase
    return r;
  endfunction : settle_cycles

endpackage : clk_pm_pkg

// File: hdl/wake_if.sv
// Wake request bundle between the power controller and its edge detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface wake_if #(parameter int N = 8);
  logic [N-1:0] src_raw;
  logic [N-1:0] mask;
  logic wake;
  modport det (input src_raw, input mask, output wake);
  modport ctl (output src_raw, output mask, input wake);
endinterface : wake_if

// File: hdl/wake_edge_detect.sv
// Synchronises asynchronous wake sources and flags masked rising edges.
// Assumes sources are active high and may be fully asynchronous.
`timescale 1ns/1ps
module wake_edge_detect #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic rst,
  wake_if.det port
);

  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;
  logic [N-1:0] hit;
  logic armed;

  genvar i;
  for (i = 0; i < N; i++)
  begin : g_src
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
      end
      else
      begin
        s1_q[i] <= port.src_raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
      end
    end
    // Edge only, even for level-configured interrupts
    assign hit[i] = s2_q[i] & ~s3_q[i] & port.mask[i];
  end

  assign port.wake = |hit;
  // Some enabled source sat low, so a later rise is a real edge
  assign armed = |(~s2_q & port.mask);

  property p_edge_only;
    @(posedge clk) disable iff (rst)
      port.wake |-> $past(armed, 1);
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("wake without a preceding low level");

endmodule : wake_edge_detect

// File: hdl/fast_osc_prescale.sv
// Divides the fast internal oscillator into system clock ticks.
// Assumes clk is the fast oscillator; en low means the oscillator is off.
`timescale 1ns/1ps
module fast_osc_prescale (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [3:0] code,
  output logic tick
);

  logic [3:0] code_q;
  logic [8:0] cnt_q;
  logic [8:0] last;
  logic wrap;

  assign last = clk_pm_pkg::prescale_ratio(code_q) - clk_pm_pkg::CNT_ONE;
  assign wrap = (cnt_q == last);
  assign tick = en & wrap;

  // New ratio taken only on a tick boundary or while en is low, so no short period
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      code_q <=
        clk_pm_pkg::SYSTEM_CLOCK_SELECT_RST[clk_pm_pkg::DIV_MSB:clk_pm_pkg::DIV_LSB];
      cnt_q <= clk_pm_pkg::CNT_ZERO;
    end
    else if (!en || wrap)
    begin
      code_q <= code;
      cnt_q <= clk_pm_pkg::CNT_ZERO;
    end
    else
    begin
      cnt_q <= cnt_q + clk_pm_pkg::CNT_ONE;
    end
  end

  property p_div_two;
    @(posedge clk) disable iff (rst)
      (tick && code_q == 4'h1 && code == 4'h1) ##1 en |->
        !tick ##1 (tick || !en);
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("divide-by-two tick spacing wrong");

endmodule : fast_osc_prescale

// File: tb/wake_source_model.sv
// Far side model: free running slow and external clocks, wake sources.
// Assumes the bench drives wake levels through set_level.
`timescale 1ns/1ps
module wake_source_model #(
  parameter real SLOW_HALF = 20.0,
  parameter real EXT_HALF = 14.0
) (
  output logic slow_32k_oscillator,
  output logic external_clock_input,
  output logic [7:0] wake_src
);
  initial
  begin
    slow_32k_oscillator = 1'b0;
    external_clock_input = 1'b0;
    wake_src = 8'h00;
  end
  // Slow clock never stops, also in SLEEP
  initial
  begin
    #0.7;
    forever #(SLOW_HALF) slow_32k_oscillator = ~slow_32k_oscillator;
  end
  initial
  begin
    #1.3;
    forever #(EXT_HALF) external_clock_input = ~external_clock_input;
  end
  // Unclocked sources: plain levels with no clock behind them
  task set_level(input int i, input logic v);
    wake_src[i] = v;
  endtask : set_level
endmodule : wake_source_model

// File: tb/test_system_clock_select_power_modes.sv
// Self-checking bench for the clock select and power mode block.
// Assumes a 10-cycle slow clock and a 7-cycle external clock.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) \
  begin errors++; $display("ERROR %s expected %h seen %h", nm, exp, got); \
  end end
module test_system_clock_select_power_modes;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_we = 1'b0;
  logic sfr_re = 1'b0;
  logic irq_req = 1'b0;
  logic [7:0] sfr_rdata, wake_src, rd_v;
  logic slow_osc, ext_clk, system_clock, cpu_clk_en, periph_clk_en;
  logic fast_osc_en, main_reg_en, cpu_resume, unlock_open;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n, j;
  int dv[8] = '{0, 1, 8, 9, 10, 11, 12, 15};
  int dr[8] = '{1, 2, 16, 32, 64, 128, 256, 256};
  int dl[4] = '{8, 16, 64, 256};

  always #2 clk = ~clk;

  system_clock_select_power_modes i_dut (.clk(clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
    .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .slow_32k_oscillator(slow_osc),
    .external_clock_input(ext_clk), .wake_src(wake_src), .irq_req(irq_req),
    .system_clock(system_clock), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .fast_osc_en(fast_osc_en),
    .main_reg_en(main_reg_en), .cpu_resume(cpu_resume),
    .unlock_open(unlock_open));

  wake_source_model i_far (.slow_32k_oscillator(slow_osc),
    .external_clock_input(ext_clk), .wake_src(wake_src));

  task results;
    $display("TB: %0d checks, %0d errors", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      results();
    end
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_we = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_we = 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_re = 1'b1;
    sfr_addr = a;
    @(negedge clk);
    sfr_re = 1'b0;
    @(negedge clk);
    d = sfr_rdata;
  endtask : rd

  task unlock;
    wr(8'hC9, 8'hAA);
    wr(8'hC9, 8'h55);
  endtask : unlock

  task set_system_clock_select(input logic [7:0] v);
    unlock();
    wr(8'h8F, v);
    wr(8'hC9, 8'h00);
  endtask : set_system_clock_select

  task set_mask(input logic [7:0] v);
    unlock();
    wr(8'h9F, v);
    wr(8'hC9, 8'h00);
  endtask : set_mask

  // Cycles between two system clock ticks, after one settling tick
  task gap(output int g);
    int k;
    k = 0;
    repeat (2)
    begin
      @(negedge clk);
      while (system_clock !== 1'b1 && k < 3000)
      begin
        @(negedge clk);
        k++;
      end
    end
    g = 1;
    @(negedge clk);
    while (system_clock !== 1'b1 && g < 3000)
    begin
      @(negedge clk);
      g++;
    end
  endtask : gap

  task wait_resume(output int g, input int lim);
    g = 0;
    while (cpu_resume !== 1'b1 && g < lim)
    begin
      @(negedge clk);
      g++;
    end
  endtask : wait_resume

  task done(input string s);
    $display("TB: test %0s done", s);
  endtask : done

  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("settle after reset", 1'b1, (n > 2500 && n < 2650));
    `CHK("regulator on", 1'b1, main_reg_en);
    rd(8'h8F, rd_v);
    `CHK("clock select reset", 8'h00, rd_v);
    rd(8'h9F, rd_v);
    `CHK("wake mask reset", 8'hFF, rd_v);
    rd(8'h10, rd_v);
    `CHK("unmapped read", 8'h00, rd_v);
    gap(n);
    `CHK("reset source fast undivided", 1, n);
    done("reset");

    wr(8'h8F, 8'h91);
    wr(8'h9F, 8'h00);
    wr(8'hC9, 8'h55);
    `CHK("lone second key", 1'b0, unlock_open);
    rd(8'h8F, rd_v);
    `CHK("locked clock select", 8'h00, rd_v);
    rd(8'h9F, rd_v);
    `CHK("locked wake mask", 8'hFF, rd_v);
    unlock();
    @(negedge clk);
    `CHK("window open", 1'b1, unlock_open);
    rd(8'hC9, rd_v);
    `CHK("unlock status", 8'h01, rd_v);
    wr(8'h8F, 8'h9D);
    rd(8'h8F, rd_v);
    `CHK("open clock select", 8'h91, rd_v);
    wr(8'hC9, 8'h00);
    @(negedge clk);
    `CHK("window closed early", 1'b0, unlock_open);
    wr(8'h8F, 8'h00);
    rd(8'h8F, rd_v);
    `CHK("closed clock select", 8'h91, rd_v);
    set_system_clock_select(8'h00);
    gap(n);
    unlock();
    repeat (248) @(negedge clk);
    `CHK("window before expiry", 1'b1, unlock_open);
    repeat (14) @(negedge clk);
    `CHK("window expired", 1'b0, unlock_open);
    done("unlock");

    for (int i = 0; i < 8; i++)
    begin
      set_system_clock_select({dv[i][3:0], 4'h0});
      gap(n);
      `CHK("prescale ratio", dr[i], n);
    end
    set_system_clock_select(8'h01);
    gap(n);
    `CHK("slow source", 1'b1, (n >= 9 && n <= 11));
    set_system_clock_select(8'h03);
    gap(n);
    `CHK("external source", 1'b1, (n >= 6 && n <= 8));
    set_system_clock_select(8'h02);
    gap(n);
    `CHK("fast source code two", 1, n);
    done("clock select");

    wr(8'h87, 8'h01);
    repeat (3) @(negedge clk);
    `CHK("idle cpu gated", 1'b0, cpu_clk_en);
    `CHK("idle peripherals run", 1'b1, periph_clk_en);
    repeat (10) @(negedge clk);
    `CHK("idle holds", 1'b0, cpu_clk_en);
    irq_req = 1'b1;
    wait_resume(n, 10);
    irq_req = 1'b0;
    `CHK("idle exit pulse", 1'b1, cpu_resume);
    repeat (10) @(negedge clk);
    `CHK("idle bit cleared", 1'b1, cpu_clk_en);
    done("idle");

    // Fast source selected before STOP, mask set first
    set_system_clock_select(8'h20);
    for (int i = 0; i < 8; i++)
    begin
      j = (i + 1) % 8;
      set_mask(8'h01 << i);
      wr(8'h87, 8'h02);
      // Entry waits for the next divide-by-four tick
      repeat (5) @(negedge clk);
      `CHK("stop osc off", 1'b0, fast_osc_en);
      `CHK("stop peripherals off", 1'b0, periph_clk_en);
      i_far.set_level(j, 1'b1);
      repeat (6) @(negedge clk);
      i_far.set_level(j, 1'b0);
      repeat (6) @(negedge clk);
      `CHK("masked source ignored", 1'b0, fast_osc_en);
      i_far.set_level(i, 1'b1);
      wait_resume(n, 10);
      `CHK("enabled source wakes", 1'b1, cpu_resume);
      i_far.set_level(i, 1'b0);
      @(negedge clk);
      `CHK("osc back", 1'b1, fast_osc_en);
    end
    set_mask(8'hFF);
    i_far.set_level(3, 1'b1);
    wr(8'h87, 8'h02);
    repeat (20) @(negedge clk);
    `CHK("level does not wake", 1'b0, cpu_clk_en);
    i_far.set_level(3, 1'b0);
    repeat (4) @(negedge clk);
    i_far.set_level(3, 1'b1);
    wait_resume(n, 10);
    `CHK("edge wakes, irq low", 1'b1, cpu_resume);
    i_far.set_level(3, 1'b0);
    repeat (10) @(negedge clk);
    `CHK("stop bit cleared", 1'b1, cpu_clk_en);
    rd(8'h8F, rd_v);
    `CHK("settings kept", 8'h20, rd_v);
    gap(n);
    `CHK("divider kept", 4, n);
    done("stop");

    for (int d = 0; d < 4; d++)
    begin
      set_system_clock_select({4'h0, d[1:0], 2'h0});
      wr(8'h87, 8'h04);
      repeat (10) @(negedge clk);
      `CHK("sleep bit alone", 1'b1, cpu_clk_en);
      wr(8'h87, 8'h06);
      repeat (3) @(negedge clk);
      `CHK("sleep regulator off", 1'b0, main_reg_en);
      i_far.set_level(0, 1'b1);
      wait_resume(n, 3000);
      i_far.set_level(0, 1'b0);
      `CHK("sleep settle", 1'b1,
           (n >= dl[d] * 10 - 10 && n <= dl[d] * 10 + 20));
      `CHK("regulator back", 1'b1, main_reg_en);
      repeat (30) @(negedge clk);
      `CHK("sleep bits cleared", 1'b1, cpu_clk_en);
    end
    done("sleep");
    results();
  end
endmodule : test_system_clock_select_power_modes
